// ===== include/cds_cfg.svh
// Clock distribution and start-up constants
// Assumes a single 40 MHz system clock; oscillator events arrive as enables
`ifndef CDS_CFG_SVH
`define CDS_CFG_SVH
`define CDS_CLK_MHZ          40
`define CDS_REF_MHZ          8
`define CDS_PLL_MHZ          96
`define CDS_USB_DIV          2
`define CDS_SCI_MAX_MHZ      12
`define CDS_TOUT_NONE        0
`define CDS_TOUT_SHORT       512
`define CDS_TOUT_LONG        8192
`define CDS_SU_EXT           6
`define CDS_SU_RES_SHORT     258
`define CDS_SU_RES_LONG      1024
`define CDS_SU_XTAL          32768
`define CDS_EXTRA_CK         14
`define CDS_PLL_LOCK_CYCLES  64
`define CDS_PRR_W            8
`define CDS_PRR_USBD         0
`define CDS_PRR_USBH         1
`define CDS_PRR_SPI          2
`define CDS_PRR_SCI          3
`define CDS_DEF_HIGH_FUSE    1'b1
`define CDS_DEF_LOW_FUSES    2'h3
`define CDS_DEF_SUT          2'h3
`endif

// ===== include/cds_pkg.sv
// Types shared by the clock distribution block
// Assumes cds_cfg.svh is compiled alongside
package cds_pkg;
   typedef enum logic [3:0] {
      CDS_ST_TIMEOUT = 4'h1,
      CDS_ST_STARTUP = 4'h2,
      CDS_ST_RUN     = 4'h4,
      CDS_ST_SLEEP   = 4'h8
   } cds_state_t;

   typedef struct packed {
      logic       source_select_high_fuse;
      logic [1:0] source_select_low_fuses;
      logic [1:0] startup_time_fuses;
   } cds_fuse_t;

   typedef struct packed {
      logic core;
      logic cpu;
      logic io;
      logic flash;
      logic nvm_write;
      logic async_timer;
      logic fast_serial;
      logic smartcard;
      logic usb_dev;
      logic usb_host;
   } cds_clk_en_t;
endpackage : cds_pkg

// ===== design/cds_divider.sv
// Enable-pulse divider: emits one pulse per N input pulses
// Assumes pulse input is one cycle wide in the clk domain
`timescale 1ns/100ps
module cds_divider #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // Pulse in and divisor
   input  wire logic         tick_in,
   input  wire logic [W-1:0] div_m1,
   // Divided pulse
   output logic              tick_out
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_q    <= '0;
         tick_out <= 1'b0;
      end else begin
         tick_out <= 1'b0;
         if (tick_in) begin
            if (cnt_q >= div_m1) begin
               cnt_q    <= '0;
               tick_out <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end
endmodule : cds_divider

// ===== design/cds_gate.sv
// Glitch-free clock-enable gate: changes only between tick pulses
// Assumes enable request is synchronous to clk
`timescale 1ns/100ps
module cds_gate (
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Source tick and request
   input  wire logic tick_in,
   input  wire logic en_req,
   // Gated tick and current state
   output logic      tick_out,
   output logic      en_q
);
   // Enable state is updated only in a cycle without a tick
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         en_q     <= 1'b0;
         tick_out <= 1'b0;
      end else begin
         if (!tick_in) begin
            en_q <= en_req;
         end
         tick_out <= tick_in & en_q;
      end
   end
endmodule : cds_gate

// ===== design/cds_clock_ctrl.sv
// Clock distribution and start-up sequencing top
// Assumes ref/rc/wdt/async oscillators arrive as one-cycle enable ticks
`timescale 1ns/100ps
`include "cds_cfg.svh"
// Function
// - PLL multiplies 8 MHz reference to 96 MHz
// - Core divider also clocks CPU, IO and flash
// - Halted CPU clock stops register file
// - Some external interrupts sensed asynchronously
// - Power reduction bits gate peripheral clocks
// - Flash read clock follows CPU clock
// - NVM write clock from RC oscillator
// - Async timer own domain, runs in sleep
// - Fast serial clock divided from root mux
// - Smartcard clock own divider, up to 12MHz
// - USB clock is PLL root mux divided by two
// - Clearing select returns root mux to external
// - Fuses decode crystal, resonator, external or reserved
// - Default fuses: crystal, longest start, timeout
// - Internal reset held for timeout after release
// - Timeout is 0, 512 or 8192 watchdog cycles
// - Ripple counter holds reset for start-up count
// - Reset uses both delays, wake only start-up
// - Select bit 1 routes PLL, 0 external
module cds_clock_ctrl
   import cds_pkg::*;
#(
   parameter int          CORE_DIV_W  = 8,
   parameter int          SPI_DIV_W   = 4,
   parameter int          SCI_DIV_W   = 4,
   parameter int unsigned TOUT_LONG   = `CDS_TOUT_LONG,
   parameter int unsigned SU_XTAL     = `CDS_SU_XTAL,
   parameter int unsigned PLL_LOCK    = `CDS_PLL_LOCK_CYCLES
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   // Oscillator ticks
   input  wire logic                   external_ref_tick,
   input  wire logic                   rc_osc_tick,
   input  wire logic                   wdt_osc_tick,
   input  wire logic                   async_osc_tick,
   // Fuses and reset sources
   input  wire cds_pkg::cds_fuse_t     fuses,
   input  wire logic                   ext_reset_active,
   input  wire logic                   wake_req,
   input  wire logic                   sleep_req,
   // Control bits
   input  wire logic                   pll_on,
   input  wire logic                   root_mux_select_bit,
   input  wire logic                   cpu_halt,
   input  wire logic [CORE_DIV_W-1:0]  core_div_m1,
   input  wire logic [SPI_DIV_W-1:0]   spi_div_m1,
   input  wire logic [SCI_DIV_W-1:0]   sci_div_m1,
   input  wire logic [`CDS_PRR_W-1:0]  power_reduction_reg_b,
   input  wire logic                   ext_int_async,
   // Status and clock enables
   output logic                        pll_lock_q,
   output logic                        root_on_pll_q,
   output logic                        internal_reset_q,
   output logic                        fuse_reserved_q,
   output logic                        ext_int_pending_q,
   output cds_pkg::cds_clk_en_t        clk_ticks_q
);
   import cds_pkg::*;

   cds_state_t                 state_q;
   logic [15:0]                tout_cnt_q;
   logic [15:0]                su_cnt_q;
   logic [15:0]                tout_target;
   logic [15:0]                su_target;
   logic [7:0]                 pll_cnt_q;
   logic [3:0]                 pll_phase_q;
   logic                       pll_tick_q;
   logic                       root_tick;
   logic                       core_tick;
   logic                       spi_tick;
   logic                       sci_tick;
   logic                       usb_half_q;
   logic                       usb_tick_q;
   logic                       run;
   logic                       g_spi;
   logic                       g_sci;
   logic                       g_usbd;
   logic                       g_usbh;
   logic                       sci_en_q;

   // Start-up counts from fuses
   always_comb begin
      case (fuses.startup_time_fuses)
         2'h0:    tout_target = 16'(`CDS_TOUT_NONE);
         2'h1:    tout_target = 16'(`CDS_TOUT_SHORT);
         default: tout_target = 16'(TOUT_LONG);
      endcase
      if (!fuses.source_select_high_fuse) begin
         su_target = 16'(`CDS_SU_EXT);
      end else if (fuses.source_select_low_fuses[0]) begin
         su_target = 16'(SU_XTAL);
      end else begin
         su_target = 16'(`CDS_SU_RES_LONG);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fuse_reserved_q <= 1'b0;
      end else begin
         fuse_reserved_q <= !fuses.source_select_high_fuse &&
                            fuses.source_select_low_fuses[1];
      end
   end

   // Start-up sequencer
   always_ff @(posedge clk) begin
      if (sys_rst || ext_reset_active) begin
         state_q    <= CDS_ST_TIMEOUT;
         tout_cnt_q <= '0;
         su_cnt_q   <= '0;
      end else begin
         case (state_q)
            CDS_ST_TIMEOUT: begin
               if (tout_cnt_q >= tout_target) begin
                  state_q <= CDS_ST_STARTUP;
               end else if (wdt_osc_tick) begin
                  tout_cnt_q <= tout_cnt_q + 16'h0001;
               end
            end
            CDS_ST_STARTUP: begin
               if (su_cnt_q >= su_target) begin
                  state_q <= CDS_ST_RUN;
               end else if (external_ref_tick) begin
                  su_cnt_q <= su_cnt_q + 16'h0001;
               end
            end
            CDS_ST_RUN: begin
               if (sleep_req) begin
                  state_q <= CDS_ST_SLEEP;
               end
            end
            CDS_ST_SLEEP: begin
               if (wake_req) begin
                  su_cnt_q <= '0;
                  state_q  <= CDS_ST_STARTUP;
               end
            end
            default: state_q <= CDS_ST_TIMEOUT;
         endcase
      end
   end

   assign run = (state_q == CDS_ST_RUN);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         internal_reset_q <= 1'b1;
      end else begin
         internal_reset_q <= !(run || state_q == CDS_ST_SLEEP);
      end
   end

   // PLL model: lock after a count, 12 output ticks per reference tick
   always_ff @(posedge clk) begin
      if (sys_rst || !pll_on) begin
         pll_cnt_q  <= '0;
         pll_lock_q <= 1'b0;
      end else if (external_ref_tick && !pll_lock_q) begin
         if (pll_cnt_q >= 8'(PLL_LOCK - 1)) begin
            pll_lock_q <= 1'b1;
         end
         pll_cnt_q <= pll_cnt_q + 8'h01;
      end
   end

   // Rate ratio 96/8 = 12 ticks; one tick per clk stands in for the burst
   always_ff @(posedge clk) begin
      if (sys_rst || !pll_lock_q) begin
         pll_phase_q <= '0;
         pll_tick_q  <= 1'b0;
      end else begin
         pll_tick_q <= 1'b0;
         if (external_ref_tick) begin
            pll_phase_q <= 4'(`CDS_PLL_MHZ / `CDS_REF_MHZ);
         end else if (pll_phase_q != 4'h0) begin
            pll_phase_q <= pll_phase_q - 4'h1;
            pll_tick_q  <= 1'b1;
         end
      end
   end

   // Root mux: switch only while neither source ticks, never unlocked
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         root_on_pll_q <= 1'b0;
      end else if (!root_mux_select_bit || !pll_lock_q) begin
         if (!external_ref_tick && !pll_tick_q) begin
            root_on_pll_q <= 1'b0;
         end
      end else if (!external_ref_tick && !pll_tick_q) begin
         root_on_pll_q <= 1'b1;
      end
   end

   assign root_tick = root_on_pll_q ? pll_tick_q : external_ref_tick;

   cds_divider #(.W(CORE_DIV_W)) u_core_div (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .tick_in  (root_tick),
      .div_m1   (core_div_m1),
      .tick_out (core_tick)
   );

   cds_divider #(.W(SPI_DIV_W)) u_spi_div (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .tick_in  (root_tick),
      .div_m1   (spi_div_m1),
      .tick_out (spi_tick)
   );

   cds_divider #(.W(SCI_DIV_W)) u_sci_div (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .tick_in  (root_tick),
      .div_m1   (sci_div_m1),
      .tick_out (sci_tick)
   );

   // USB divide by two, only on PLL
   always_ff @(posedge clk) begin
      if (sys_rst || !root_on_pll_q) begin
         usb_half_q <= 1'b0;
         usb_tick_q <= 1'b0;
      end else begin
         usb_tick_q <= 1'b0;
         if (root_tick) begin
            usb_half_q <= ~usb_half_q;
            usb_tick_q <= usb_half_q;
         end
      end
   end

   cds_gate u_gate_spi (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .tick_in  (spi_tick),
      .en_req   (run && !power_reduction_reg_b[`CDS_PRR_SPI]),
      .tick_out (g_spi),
      .en_q     ()
   );

   cds_gate u_gate_sci (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .tick_in  (sci_tick),
      .en_req   (run && !power_reduction_reg_b[`CDS_PRR_SCI]),
      .tick_out (g_sci),
      .en_q     (sci_en_q)
   );

   cds_gate u_gate_usbd (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .tick_in  (usb_tick_q),
      .en_req   (run && !power_reduction_reg_b[`CDS_PRR_USBD]),
      .tick_out (g_usbd),
      .en_q     ()
   );

   cds_gate u_gate_usbh (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .tick_in  (usb_tick_q),
      .en_req   (run && !power_reduction_reg_b[`CDS_PRR_USBH]),
      .tick_out (g_usbh),
      .en_q     ()
   );

   // Clock tick outputs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clk_ticks_q <= '0;
      end else begin
         clk_ticks_q.core        <= core_tick && run;
         clk_ticks_q.cpu         <= core_tick && run && !cpu_halt;
         clk_ticks_q.io          <= core_tick && run;
         clk_ticks_q.flash       <= core_tick && run && !cpu_halt;
         clk_ticks_q.nvm_write   <= rc_osc_tick && !internal_reset_q;
         clk_ticks_q.async_timer <= async_osc_tick && !internal_reset_q;
         clk_ticks_q.fast_serial <= g_spi;
         clk_ticks_q.smartcard   <= g_sci;
         clk_ticks_q.usb_dev     <= g_usbd;
         clk_ticks_q.usb_host    <= g_usbh;
      end
   end

   // External interrupt sensed without the I/O clock tick
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ext_int_pending_q <= 1'b0;
      end else if (ext_int_async) begin
         ext_int_pending_q <= 1'b1;
      end else if (clk_ticks_q.io) begin
         ext_int_pending_q <= 1'b0;
      end
   end

   // Checks
   sequence s_lock_then_select;
      pll_lock_q && root_mux_select_bit && !external_ref_tick && !pll_tick_q;
   endsequence

   AST_MUX_NEEDS_LOCK: assert property (@(posedge clk) disable iff (sys_rst)
      root_on_pll_q |-> $past(pll_lock_q))
      else $error("root mux on PLL without lock");
   AST_MUX_TO_PLL: assert property (@(posedge clk) disable iff (sys_rst)
      s_lock_then_select |=> root_on_pll_q)
      else $error("root mux did not take PLL");
   AST_MUX_BACK: assert property (@(posedge clk) disable iff (sys_rst)
      (!root_mux_select_bit && !external_ref_tick && !pll_tick_q) |=> !root_on_pll_q)
      else $error("root mux did not return to external");
   AST_USB_ONLY_PLL: assert property (@(posedge clk) disable iff (sys_rst)
      usb_tick_q |-> $past(root_on_pll_q))
      else $error("USB tick without PLL");
   AST_GATED_IN_RESET: assert property (@(posedge clk) disable iff (sys_rst)
      internal_reset_q |-> !clk_ticks_q.core)
      else $error("core ticks during internal reset");
   AST_CPU_HALT: assert property (@(posedge clk) disable iff (sys_rst)
      $past(cpu_halt) |-> !clk_ticks_q.cpu && !clk_ticks_q.flash)
      else $error("CPU clock ran while halted");
   AST_WAKE_SKIPS_TIMEOUT: assert property (@(posedge clk) disable iff (sys_rst)
      (state_q == CDS_ST_SLEEP && wake_req && !ext_reset_active) |=> state_q == CDS_ST_STARTUP)
      else $error("wake did not go to start-up count");
   AST_RESET_TIMEOUT: assert property (@(posedge clk) disable iff (sys_rst)
      (state_q == CDS_ST_TIMEOUT) |-> internal_reset_q || $past(state_q) != CDS_ST_TIMEOUT)
      else $error("internal reset released during timeout");
   AST_PRR_GATE: assert property (@(posedge clk) disable iff (sys_rst)
      !sci_en_q |-> ##2 !clk_ticks_q.smartcard)
      else $error("smartcard clock ran while gated");
   AST_PRR_ENABLE: assert property (@(posedge clk) disable iff (sys_rst)
      (power_reduction_reg_b[`CDS_PRR_SCI] && !sci_tick) |=> !sci_en_q)
      else $error("smartcard gate stayed open");
   AST_RESERVED: assert property (@(posedge clk) disable iff (sys_rst)
      (!fuses.source_select_high_fuse && fuses.source_select_low_fuses[1]) |=> fuse_reserved_q)
      else $error("reserved fuse code not flagged");
endmodule : cds_clock_ctrl

// ===== testbench/cds_ref_source.sv
// External reference model: emits one-cycle ticks of the applied clock
// Assumes a period in system cycles set by the bench (5 gives 8 MHz at 40 MHz)
`timescale 1ns/100ps
module cds_ref_source (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Period in system cycles, 2 or more
   input  wire logic [7:0] period,
   // Reference tick
   output logic            ref_tick
);
   logic [7:0] phase_q;

   // Source runs from power-up at the rate set by period
   always @(negedge clk) begin
      if (phase_q >= period - 8'h01) begin
         phase_q  <= 8'h00;
         ref_tick <= 1'b1;
      end else begin
         phase_q  <= phase_q + 8'h01;
         ref_tick <= 1'b0;
      end
   end

   initial begin
      phase_q  = 8'h00;
      ref_tick = 1'b0;
   end
endmodule : cds_ref_source

// ===== testbench/cds_clock_ctrl_test.sv
// Self-checking bench for the clock distribution and start-up block
// Assumes shortened counts: long timeout 16, crystal start-up 32, lock 4
`timescale 1ns/100ps
module cds_clock_ctrl_test;
   import cds_pkg::*;
   logic        clk, sys_rst, ref_tick, rc_osc_tick, wdt_osc_tick, async_osc_tick;
   logic        ext_reset_active, wake_req, sleep_req, pll_on, mux_sel, cpu_halt;
   logic        ext_int_async, pll_lock_q, root_on_pll_q, internal_reset_q;
   logic        fuse_reserved_q, ext_int_pending_q;
   logic [7:0]  core_div_m1, prr, ref_period;
   logic [3:0]  spi_div_m1, sci_div_m1;
   cds_fuse_t   fuses;
   cds_clk_en_t clk_ticks_q;
   logic [9:0]  v;
   int          fails, checked, osc_cnt, el, refs, rcs, asys, i, d, s, c;
   int          cnt[10];
   cds_fuse_t   cases[6];

   cds_ref_source u_cds_ref_source (.clk(clk), .sys_rst(sys_rst), .period(ref_period),
                                    .ref_tick(ref_tick));
   cds_clock_ctrl #(.TOUT_LONG(16), .SU_XTAL(32), .PLL_LOCK(4)) u_cds_clock_ctrl (
      .clk(clk), .sys_rst(sys_rst), .external_ref_tick(ref_tick),
      .rc_osc_tick(rc_osc_tick), .wdt_osc_tick(wdt_osc_tick),
      .async_osc_tick(async_osc_tick), .fuses(fuses), .ext_reset_active(ext_reset_active),
      .wake_req(wake_req), .sleep_req(sleep_req), .pll_on(pll_on),
      .root_mux_select_bit(mux_sel), .cpu_halt(cpu_halt), .core_div_m1(core_div_m1),
      .spi_div_m1(spi_div_m1), .sci_div_m1(sci_div_m1), .power_reduction_reg_b(prr),
      .ext_int_async(ext_int_async), .pll_lock_q(pll_lock_q), .root_on_pll_q(root_on_pll_q),
      .internal_reset_q(internal_reset_q), .fuse_reserved_q(fuse_reserved_q),
      .ext_int_pending_q(ext_int_pending_q), .clk_ticks_q(clk_ticks_q));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Oscillator ticks: watchdog every cycle, RC every 3rd, async every 7th
   always @(negedge clk) begin
      osc_cnt        <= osc_cnt + 1;
      rc_osc_tick    <= (osc_cnt % 3 == 0);
      wdt_osc_tick   <= 1'b1;
      async_osc_tick <= (osc_cnt % 7 == 0);
   end

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   task print_verdict;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   function automatic int tout_cycles(input cds_fuse_t f);
      case (f.startup_time_fuses)
         2'h0: return 0;
         2'h1: return 512;
         default: return 16;
      endcase
   endfunction : tout_cycles

   function automatic int su_count(input cds_fuse_t f);
      if (f.source_select_high_fuse == 1'b0) return 6;
      return f.source_select_low_fuses[0] ? 32 : 1024;
   endfunction : su_count

   // Waits for the internal reset to drop, ticks must stay silent meanwhile
   task wait_run;
      el = 0;
      while (internal_reset_q === 1'b1 && el < 20000) begin
         @(negedge clk);
         el++;
         if (clk_ticks_q !== 10'h000) check("ticks in reset", clk_ticks_q, 10'h000);
      end
   endtask : wait_run

   task start(input cds_fuse_t f);
      sys_rst = 1'b1;
      fuses   = f;
      repeat (10) @(negedge clk);
      check("reset held", internal_reset_q, 1'b1);
      check("ticks at reset", clk_ticks_q, 10'h000);
      sys_rst = 1'b0;
      wait_run();
      c = tout_cycles(f) + su_count(f) * ref_period;
      check("startup span", (el >= c - ref_period) && (el <= c + ref_period + 8), 1'b1);
      check("reserved code", fuse_reserved_q,
            !f.source_select_high_fuse && f.source_select_low_fuses[1]);
   endtask : start

   task count_win(input int cyc);
      cnt  = '{default: 0};
      refs = 0;
      rcs  = 0;
      asys = 0;
      repeat (cyc) begin
         @(negedge clk);
         v = clk_ticks_q;
         for (i = 0; i < 10; i++) if (v[i] === 1'b1) cnt[i]++;
         refs += ref_tick;
         rcs  += rc_osc_tick;
         asys += async_osc_tick;
      end
   endtask : count_win

   task near(input string name, input int seen, input int exp);
      check(name, (seen >= exp - 1) && (seen <= exp + 1), 1'b1);
   endtask : near

   initial begin
      {sys_rst, ext_reset_active, wake_req, sleep_req, pll_on} = 5'h10;
      {mux_sel, cpu_halt, ext_int_async} = 3'h0;
      {rc_osc_tick, wdt_osc_tick, async_osc_tick} = 3'h0;
      core_div_m1 = 8'h00;
      spi_div_m1  = 4'h0;
      sci_div_m1  = 4'h0;
      prr         = 8'h00;
      ref_period  = 8'h05;
      fuses       = cds_fuse_t'(5'h1F);
      osc_cnt     = 0;
      fails       = 0;
      checked     = 0;
      void'($urandom(46960));
      cases = '{cds_fuse_t'(5'h1F), cds_fuse_t'(5'h00), cds_fuse_t'(5'h09),
                cds_fuse_t'(5'h16), cds_fuse_t'($urandom % 32), cds_fuse_t'($urandom % 32)};
      foreach (cases[k]) start(cases[k]);
      start(cds_fuse_t'(5'h01));
      for (int r = 0; r < 3; r++) begin
         d = $urandom % 8;
         s = $urandom % 4;
         core_div_m1 = d[7:0];
         spi_div_m1  = s[3:0];
         sci_div_m1  = 4'(3 - s);
         repeat (8) @(negedge clk);
         count_win(5 * (d + 1) * 20);
         near("core", cnt[9], refs / (d + 1));
         check("io", cnt[7], cnt[9]);
         check("flash", cnt[6], cnt[8]);
         near("fast serial", cnt[3], refs / (s + 1));
         near("smartcard", cnt[2], refs / (4 - s));
         check("usb off root", cnt[1], 0);
         near("nvm write", cnt[5], rcs);
      end
      cpu_halt = 1'b1;
      prr      = 8'h0C;
      repeat (8) @(negedge clk);
      count_win(200);
      check("cpu halted", cnt[8] + cnt[6], 0);
      check("core runs", cnt[9] > 0, 1'b1);
      check("gated", cnt[3] + cnt[2], 0);
      near("nvm in halt", cnt[5], rcs);
      cpu_halt = 1'b0;
      mux_sel  = 1'b1;
      repeat (20) @(negedge clk);
      check("no lock no pll", root_on_pll_q, 1'b0);
      mux_sel    = 1'b0;
      ref_period = 8'd16;
      pll_on     = 1'b1;
      for (c = 0; c < 200 && pll_lock_q !== 1'b1; c++) @(negedge clk);
      check("lock", pll_lock_q, 1'b1);
      mux_sel = 1'b1;
      repeat (4) @(negedge clk);
      check("on pll", root_on_pll_q, 1'b1);
      repeat (40) @(negedge clk);
      count_win(16 * 20);
      near("usb rate", cnt[1], refs * 6);
      check("usb pair", cnt[0], cnt[1]);
      prr = 8'h01;
      repeat (40) @(negedge clk);
      count_win(160);
      check("usb dev gated", cnt[1], 0);
      check("usb host on", cnt[0] > 0, 1'b1);
      mux_sel = 1'b0;
      repeat (40) @(negedge clk);
      check("back to ext", root_on_pll_q, 1'b0);
      pll_on     = 1'b0;
      ref_period = 8'h05;
      ext_int_async = 1'b1;
      @(negedge clk);
      ext_int_async = 1'b0;
      check("int pending", ext_int_pending_q, 1'b1);
      ext_reset_active = 1'b1;
      repeat (3) @(negedge clk);
      check("ext reset held", internal_reset_q, 1'b1);
      ext_reset_active = 1'b0;
      wait_run();
      check("ext reset span", (el >= 537) && (el <= 555), 1'b1);
      sleep_req = 1'b1;
      @(negedge clk);
      sleep_req = 1'b0;
      count_win(70);
      check("sleep no reset", internal_reset_q, 1'b0);
      near("async in sleep", cnt[4], asys);
      wake_req = 1'b1;
      @(negedge clk);
      wake_req = 1'b0;
      @(negedge clk);
      check("wake reset", internal_reset_q, 1'b1);
      wait_run();
      check("wake span", (el >= 20) && (el <= 50), 1'b1);
      print_verdict();
   end

   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      print_verdict();
   end
endmodule : cds_clock_ctrl_test
